// file: common/stwfs_pkg.sv
package stwfs_pkg;

  // array shape
  localparam int MEM_AW = 15;
  localparam int MEM_DW = 8;
  localparam int MEM_DEPTH = 32768;
  localparam logic [MEM_AW-1:0] ADDR_RST = 15'h0000;
  localparam logic [MEM_AW-1:0] ADDR_LAST = 15'h7fff;

  // slave address byte layout
  localparam int SA_TYPE_HI = 7;
  localparam int SA_TYPE_LO = 4;
  localparam int SA_SEL_HI = 3;
  localparam int SA_SEL_LO = 1;
  localparam int SA_RW = 0;
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam int HS_CODE_LO = 3;

  // serial byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;

  // pin synchroniser vector layout
  localparam int PIN_W = 6;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SEL_LO = 2;
  localparam int PIN_SEL_HI = 4;
  localparam int PIN_WP = 5;
  // released bus and pulled-down pins after reset
  localparam logic [PIN_W-1:0] PIN_RST = 6'h03;

  // bus register map, byte addresses
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] OFF_ID = 8'h00;
  localparam logic [REG_AW-1:0] OFF_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] OFF_CTRL = 8'h08;

  // control register fields
  localparam int CTRL_EN = 0;
  localparam logic CTRL_EN_RST = 1'b1;

  // status register fields
  localparam int ST_ADDR_LO = 0;
  localparam int ST_HS = 16;
  localparam int ST_BUSY = 17;
  localparam int ST_WP = 18;
  localparam int ST_DSEL_LO = 20;

  localparam logic [31:0] HRDATA_RST = 32'h0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_RACK = 5'b10000
  } stwfs_state_t;

  typedef enum logic [3:0] {
    K_SLAVE = 4'b0001,
    K_AHI   = 4'b0010,
    K_ALO   = 4'b0100,
    K_DATA  = 4'b1000
  } stwfs_kind_t;

endpackage

// file: common/stwfs_mem_if.sv
`timescale 1ns/10ps
interface stwfs_mem_if;
  import stwfs_pkg::*;
  logic [MEM_AW-1:0] addr;
  logic [MEM_DW-1:0] wdata;
  logic we;
  logic [MEM_DW-1:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// file: verilog/stwfs_mem.sv
`timescale 1ns/10ps
module stwfs_mem
  import stwfs_pkg::*;
(
  input wire logic clock,
  stwfs_mem_if.mem port
);

  // no reset on the array: contents survive like the real cells
  logic [MEM_DW-1:0] cells [MEM_DEPTH];

  always_ff @(posedge clock) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
    port.rdata <= cells[port.addr];
  end

endmodule

// file: verilog/stwfs_top.sv
`timescale 1ns/10ps
// How it works
// RULE1: the slave holds 32768 byte locations, each readable and writable.
// RULE2: a received data byte is written to the array at the clock fall that ends its 8th bit.
// RULE3: there is no busy time, so a new start is served right after a write.
// RULE4: the slave answers only when the three select bits match the select pins.
// RULE5: select pins left open are taken as low, since the part pulls them down; the code has no pull-down and samples the pins as driven.
// RULE6: data is sampled on clock rising edges and changed after falling edges.
// RULE7: a high write-protect blocks every array write, a low one allows all.
// RULE8: the data line is only pulled low or released, never driven high.
// RULE9: a fixed identification word can be read and no write changes it.
// RULE10: any master rate from 100 kHz up to 3.4 MHz is followed.
// RULE11: the first byte holds type code, select value and the read/write bit.
// RULE12: a 15-bit address latch loads from two bytes, steps per byte and wraps.
// RULE13: reads send 8 bits, continue on acknowledge and stop on no-acknowledge.
// RULE14: the master code enters high-speed mode and the next stop leaves it.
// RULE15: under write protect bytes are still acknowledged but not stored.
module stwfs_top
  import stwfs_pkg::*;
#(
  // arbitrary neutral identification value
  parameter logic [31:0] ID_VALUE = 32'h0000_5a01,
  // arbitrary neutral device type code
  parameter logic [3:0] DEV_TYPE = 4'h5
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] device_select_pins,
  input wire logic write_protect,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_f;
  logic [PIN_W-1:0] pin_p;

  // open select and protect pins resolve low on the board pull-downs
  assign pin_raw = {write_protect, device_select_pins, sda_in, scl_in}; // RULE5

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
      pin_s3 <= PIN_RST;
      pin_p <= PIN_RST;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_p <= pin_f;
    end
  end

  // a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_filt
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pin_f[gi] <= PIN_RST[gi];
        end else if (pin_s2[gi] == pin_s3[gi]) begin
          pin_f[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // bus condition detection

  wire scl_f = pin_f[PIN_SCL];
  wire sda_f = pin_f[PIN_SDA];
  wire scl_p = pin_p[PIN_SCL];
  wire sda_p = pin_p[PIN_SDA];
  wire [2:0] dsel_f = pin_f[PIN_SEL_HI:PIN_SEL_LO];
  wire wp_f = pin_f[PIN_WP];

  // 100 MHz sampling keeps several samples per half period even at 3.4 MHz
  wire scl_rise = scl_f & ~scl_p; // RULE10
  wire scl_fall = ~scl_f & scl_p;
  wire start_cond = scl_f & scl_p & sda_p & ~sda_f;
  wire stop_cond = scl_f & scl_p & ~sda_p & sda_f;

  ////////////////////////////////////////////////////////////////////////
  // register bus decode

  logic enable;
  logic wr_pend;
  logic [REG_AW-1:0] wr_off;

  wire ahb_go = hsel & hready & htrans[1];
  wire ahb_rd = ahb_go & ~hwrite;
  wire [REG_AW-1:0] rd_off = haddr[REG_AW-1:0];
  wire ctrl_wr = wr_pend & (wr_off == OFF_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // serial engine state

  stwfs_state_t state;
  stwfs_state_t next_state;
  stwfs_kind_t kind;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [MEM_AW-1:0] cur_addr;
  logic [6:0] addr_hi;
  logic read_mode;
  logic hs_mode;
  logic mst_ack;
  logic drive_low;

  stwfs_mem_if mem_bus ();

  stwfs_mem u_mem (
    .clock(clock),
    .port(mem_bus.mem)
  );

  wire [7:0] rx_byte = shift;
  wire byte_done = (bit_cnt == BITS_PER_BYTE);
  wire [3:0] bit_inc = bit_cnt + 4'h1;
  wire [MEM_AW-1:0] addr_inc = cur_addr + 15'h0001;
  // the 7fff to 0000 step falls out of the 15-bit width
  wire [MEM_AW-1:0] addr_step = addr_inc; // RULE12

  // slave address byte split
  wire [3:0] sa_type = rx_byte[SA_TYPE_HI:SA_TYPE_LO]; // RULE11
  wire [2:0] sa_sel = rx_byte[SA_SEL_HI:SA_SEL_LO];
  wire sa_read = rx_byte[SA_RW];
  wire sel_match = (sa_sel == dsel_f); // RULE4
  wire addr_match = enable & (sa_type == DEV_TYPE) & sel_match;
  wire is_hs_code = (rx_byte[7:HS_CODE_LO] == HS_CODE); // RULE14

  // phase decisions at the falling edge that ends a byte or an acknowledge bit
  wire rx_end = (state == ST_RX) & scl_fall & byte_done;
  wire ack_end = (state == ST_ACK) & scl_fall;
  wire tx_end = (state == ST_TX) & scl_fall & byte_done;
  wire rack_end = (state == ST_RACK) & scl_fall;

  wire data_in = rx_end & (kind == K_DATA);
  // protected bytes are acked but never reach the array
  wire mem_write = data_in & ~wp_f; // RULE7 RULE15

  // the array is always addressed by the current latch
  assign mem_bus.addr = cur_addr; // RULE1
  assign mem_bus.wdata = rx_byte;
  assign mem_bus.we = mem_write; // RULE2

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_RX: begin
        if (rx_end) begin
          if (kind != K_SLAVE) begin
            next_state = ST_ACK;
          end else if (addr_match) begin
            next_state = ST_ACK;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_ACK: begin
        if (ack_end) begin
          next_state = read_mode ? ST_TX : ST_RX;
        end
      end
      ST_TX: begin
        if (tx_end) begin
          next_state = ST_RACK;
        end
      end
      ST_RACK: begin
        if (rack_end) begin
          next_state = mst_ack ? ST_TX : ST_IDLE; // RULE13
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a start aborts anything and a stop ends anything
    if (start_cond) begin
      next_state = ST_RX; // RULE3
    end else if (stop_cond) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte kind and direction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kind <= K_SLAVE;
      read_mode <= 1'b0;
    end else if (start_cond) begin
      kind <= K_SLAVE;
      read_mode <= 1'b0;
    end else if (rx_end) begin
      case (kind)
        K_SLAVE: begin
          kind <= K_AHI;
          read_mode <= sa_read;
        end
        K_AHI: begin
          kind <= K_ALO;
        end
        K_ALO: begin
          kind <= K_DATA;
        end
        K_DATA: begin
          kind <= K_DATA;
        end
        default: begin
          kind <= K_SLAVE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift register and bit counter

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt <= BIT_CNT_RST;
      shift <= 8'h00;
    end else if (start_cond) begin
      bit_cnt <= BIT_CNT_RST;
    end else if (state == ST_RX && scl_rise) begin
      shift <= {shift[6:0], sda_f}; // RULE6
      bit_cnt <= bit_inc;
    end else if (ack_end) begin
      bit_cnt <= read_mode ? 4'h1 : BIT_CNT_RST;
      shift <= {mem_bus.rdata[6:0], 1'b0};
    end else if (rack_end) begin
      bit_cnt <= 4'h1;
      shift <= {mem_bus.rdata[6:0], 1'b0};
    end else if (state == ST_TX && scl_fall && !byte_done) begin
      bit_cnt <= bit_inc;
      shift <= {shift[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address latch

  // keeps its value across transfers; only bytes move it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_addr <= ADDR_RST;
      addr_hi <= 7'h00;
    end else if (rx_end && kind == K_AHI) begin
      addr_hi <= rx_byte[6:0];
    end else if (rx_end && kind == K_ALO) begin
      cur_addr <= {addr_hi, rx_byte}; // RULE12
    end else if (data_in || tx_end) begin
      cur_addr <= addr_step; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master acknowledge and high-speed flag

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mst_ack <= 1'b0;
    end else if (state == ST_RACK && scl_rise) begin
      mst_ack <= ~sda_f; // RULE13
    end
  end

  // a master code is never acked; the repeated start follows
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_mode <= 1'b0;
    end else if (stop_cond) begin
      hs_mode <= 1'b0; // RULE14
    end else if (rx_end && kind == K_SLAVE && is_hs_code) begin
      hs_mode <= 1'b1; // RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data line drive

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drive_low <= 1'b0;
    end else if (start_cond || stop_cond) begin
      drive_low <= 1'b0;
    end else if (rx_end) begin
      drive_low <= (kind != K_SLAVE) | addr_match;
    end else if (ack_end) begin
      drive_low <= read_mode & ~mem_bus.rdata[7]; // RULE6
    end else if (rack_end) begin
      drive_low <= mst_ack & ~mem_bus.rdata[7];
    end else if (tx_end) begin
      drive_low <= 1'b0;
    end else if (state == ST_TX && scl_fall) begin
      drive_low <= ~shift[7]; // RULE6
    end
  end

  // output level is fixed low; only the enable toggles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0; // RULE8
      sda_oe <= drive_low; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus slave

  wire [31:0] status_word = {8'h00, 1'b0, dsel_f, 1'b0, wp_f,
    state != ST_IDLE, hs_mode, 1'b0, cur_addr};
  wire [31:0] ctrl_word = {31'h0000_0000, enable};
  wire hit_id = (rd_off == OFF_ID);
  wire hit_st = (rd_off == OFF_STATUS);
  wire hit_ctl = (rd_off == OFF_CTRL);
  // writes to the identification word decode to nothing
  wire [31:0] rd_mux = hit_id ? ID_VALUE : // RULE9
    hit_st ? status_word :
    hit_ctl ? ctrl_word : HRDATA_RST;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_off <= OFF_ID;
    end else begin
      wr_pend <= ahb_go & hwrite;
      if (ahb_go) begin
        wr_off <= rd_off;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable <= CTRL_EN_RST;
    end else if (ctrl_wr) begin
      enable <= hwdata[CTRL_EN];
    end
  end

  // read data caught at the address edge: zero wait states
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= HRDATA_RST;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ahb_rd) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule

// file: verif/stwfs_checker.sv
`timescale 1ns/10ps
module stwfs_checker
  import stwfs_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0000_5a01
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire rd_id = rd_take && haddr[7:0] == OFF_ID;
  ////////////////////////////////////////////////////////////////////////
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data pin value not low");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  no_busy_a: assert property (!$past(rst) |-> hreadyout)
    else $error("bus slave stalled");
  id_read_a: assert property (rd_id |=> hrdata == ID_VALUE)
    else $error("identification word wrong");
  unmapped_zero_a: assert property
    (rd_take && haddr[7:0] > OFF_CTRL |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  change_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed with clock high");
  drive_after_fall_a: assert property
    ($rose(sda_oe) |-> !scl_in && $past(scl_in, 8))
    else $error("data drive not after clock fall");
  // ack then an all-low first read byte holds the line nine bit times
  drive_bounded_a: assert property ($rose(sda_oe) |-> ##[1:160] !sda_oe)
    else $error("data line held past one byte");
  ////////////////////////////////////////////////////////////////////////
  ack_seen_c: cover property ($rose(sda_oe));
  id_seen_c: cover property (rd_id);
  status_seen_c: cover property (rd_take && haddr[7:0] == OFF_STATUS);
endmodule

bind stwfs_top stwfs_checker #(.ID_VALUE(ID_VALUE)) chk (.clock, .rst,
  .scl_in, .sda_out, .sda_oe, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp);

// file: verif/stwfs_master.sv
`timescale 1ns/10ps
module stwfs_master (
  input wire logic clock,
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // 160 ns bit, data moves mid-low so no false start or stop
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bit_io(input logic b, output logic r);
    w(4);
    sda_pull <= !b;
    w(4);
    scl <= 1'b1;
    w(8);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    w(4);
    sda_pull <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_pull <= 1'b1;
    w(8);
    scl <= 1'b0;
  endtask
  task automatic stop();
    w(4);
    sda_pull <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_pull <= 1'b0;
    w(8);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // nack on the last byte releases the line for the stop
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import stwfs_pkg::*;
  // arbitrary neutral type code and identification word
  localparam logic [3:0] TB_TYPE = 4'h5;
  localparam logic [31:0] TB_ID = 32'h0000_5a01;
  logic clock, rst, scl, sda_pull, sda_out, sda_oe, wp, hsel, hwrite;
  logic [2:0] dsel, hsize;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic hreadyout, hresp;
  logic [14:0] a;
  logic [7:0] mem_m [logic [14:0]];
  integer seed, checks, mismatches;
  wire hready = hreadyout;
  wire sda = !(sda_oe | sda_pull);
  stwfs_top #(.ID_VALUE(TB_ID), .DEV_TYPE(TB_TYPE)) dut (.clock, .rst,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .device_select_pins(dsel), .write_protect(wp), .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);
  stwfs_master m (.clock, .scl, .sda_pull, .sda);
  initial begin
    clock = 1'b0;
    forever #5 clock = !clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    // select stays up: a following call raises it again in this time step
    r = hrdata;
  endtask
  function automatic logic [7:0] sb(input logic rw);
    return {TB_TYPE, dsel, rw};
  endfunction
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic k;
    m.wr(b, k);
    `CHK(k, exp_ack)
  endtask
  task automatic set_addr(input logic [14:0] ad);
    m.start();
    send(sb(1'b0), 1'b1);
    send({1'b0, ad[14:8]}, 1'b1);
    send(ad[7:0], 1'b1);
  endtask
  task automatic wr_mem(input logic [14:0] ad, input int n);
    logic [7:0] d;
    set_addr(ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      send(d, 1'b1);
      if (!wp) mem_m[ad + 15'(i)] = d;
    end
    m.stop();
  endtask
  task automatic rd_mem(input logic [14:0] ad, input int n);
    logic [7:0] d;
    set_addr(ad);
    m.start();
    send(sb(1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rd(i < n - 1, d);
      `CHK(d, mem_m[ad + 15'(i)])
    end
    m.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h6b14bc53;
    checks = 0;
    mismatches = 0;
    rst = 1'b1;
    {dsel, wp, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    ahb(1'b0, OFF_ID, 32'h0);
    `CHK(r, TB_ID)
    ahb(1'b1, OFF_ID, 32'hffff_ffff);
    ahb(1'b0, OFF_ID, 32'h0);
    `CHK(r, TB_ID)
    ahb(1'b0, 8'h0c, 32'h0);
    `CHK(r, 32'h0)
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK(r[22:20], 3'h0)
    // back to back: write burst then read with no polling
    a = 15'($random(seed));
    wr_mem(a, 4);
    rd_mem(a, 4);
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK(r[14:0], a + 15'd4)
    `CHK(r[ST_BUSY], 1'b0)
    wr_mem(ADDR_LAST, 2);
    rd_mem(ADDR_LAST, 2);
    dsel <= 3'($random(seed));
    m.w(8);
    for (int s = 0; s < 8; s++) begin
      m.start();
      send({TB_TYPE, 3'(s), 1'b0}, 3'(s) == dsel);
      m.stop();
    end
    m.start();
    send({~TB_TYPE, dsel, 1'b0}, 1'b0);
    m.stop();
    wp <= 1'b1;
    m.w(8);
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK(r[ST_WP], 1'b1)
    wr_mem(a, 2);
    wp <= 1'b0;
    rd_mem(a, 2);
    m.start();
    send(8'h0a, 1'b0);
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK(r[ST_HS], 1'b1)
    m.stop();
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK(r[ST_HS], 1'b0)
    ahb(1'b1, OFF_CTRL, 32'h0);
    m.start();
    send(sb(1'b0), 1'b0);
    m.stop();
    results();
  end
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    results();
  end
endmodule
